// ---- hw/i2c_tenbit_pkg.sv ----
// constants for the ten-bit multi-address target matcher
package i2c_tenbit_pkg;
  localparam int           ADDR_WIDTH   = 10;
  localparam int           MAX_ADDRS    = 4;
  localparam logic [4:0]   TENBIT_PREFIX = 5'h1e;
  localparam int           PREFIX_LSB   = 3;
  localparam int           HIGH_LSB     = 1;
  localparam int           DIR_BIT      = 0;
  localparam logic [9:0]   OWN_ADDR_RESET = 10'h000;
endpackage

// ---- hw/i2c_tenbit_match.sv ----
// ten-bit own-address recognition with up to four identities
// Functional notes
// - hold up to four separate ten-bit identities
// - first byte is 11110, two MSBs, direction
// - second byte holds the low eight bits
// - ack first byte on any upper-bit match
// - ack second byte only on one-address match
// - only full match receives following data
module i2c_tenbit_match #(
  parameter int NUM_ADDRS = 4
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // configuration
  input  wire logic                   multiEnable,
  input  wire logic [NUM_ADDRS-1:0]   ownEnable,
  input  wire logic [NUM_ADDRS*10-1:0] ownAddr,
  // byte stream from the bus shifter
  input  wire logic                   startSeen,
  input  wire logic                   stopSeen,
  input  wire logic                   byteValid,
  input  wire logic [7:0]             byteData,
  // acknowledge and data outputs
  output logic                        ackDrive,
  output logic                        selected,
  output logic [1:0]                  matchIndex,
  output logic                        dataValid,
  output logic [7:0]                  dataOut
);

  // parameter range check at elaboration
  if (NUM_ADDRS < 1 || NUM_ADDRS > i2c_tenbit_pkg::MAX_ADDRS) begin : g_bad_count
    $error("NUM_ADDRS out of range");
  end

  typedef enum logic [1:0] {IDLE, SECOND, DATA, IGNORE} phase_t;

  typedef struct packed {
    phase_t                 phase;
    logic [NUM_ADDRS-1:0]   candidate;
    logic [1:0]             firstHigh;
    logic                   ackDrive;
    logic                   selected;
    logic [1:0]             matchIndex;
    logic                   dataValid;
    logic [7:0]             dataOut;
  } state_t;

  state_t s;
  state_t next_s;

  // identity i out of the packed address bus
  function automatic logic [9:0] addrOf(input logic [NUM_ADDRS*10-1:0] all, input int i);
    addrOf = all[i*10 +: 10];
  endfunction

  // upper two bits of an identity
  function automatic logic [1:0] highOf(input logic [9:0] a);
    highOf = a[9:8];
  endfunction

  // lower eight bits of an identity
  function automatic logic [7:0] lowOf(input logic [9:0] a);
    lowOf = a[7:0];
  endfunction

  logic [NUM_ADDRS-1:0] highHit;
  logic [NUM_ADDRS-1:0] fullHit;
  logic                 firstOk;
  logic                 anyFull;
  logic                 firstPass;
  logic [1:0]           byteHigh;
  logic [9:0]           matchedAddr;
  logic                 matchedOn;

  always_comb begin
    byteHigh = byteData[i2c_tenbit_pkg::HIGH_LSB +: 2];
    firstOk  = byteData[7:i2c_tenbit_pkg::PREFIX_LSB] == i2c_tenbit_pkg::TENBIT_PREFIX;
    for (int i = 0; i < NUM_ADDRS; i++) begin
      highHit[i] = ownEnable[i] && (highOf(addrOf(ownAddr, i)) == byteHigh);
      fullHit[i] = s.candidate[i] && (lowOf(addrOf(ownAddr, i)) == byteData);
    end
    anyFull   = |fullHit;
    firstPass = firstOk && |highHit;
  end

  // identity named by the registered index, for the checks below
  always_comb begin
    matchedAddr = addrOf(ownAddr, int'(s.matchIndex));
    matchedOn   = ownEnable[s.matchIndex];
  end

  always_comb begin
    next_s           = s;
    next_s.ackDrive  = 1'b0;
    next_s.dataValid = 1'b0;
    if (startSeen || stopSeen || !multiEnable) begin
      next_s.phase     = IDLE;
      next_s.selected  = 1'b0;
      next_s.candidate = '0;
    end else if (byteValid) begin
      unique case (s.phase)
        IDLE: begin
          if (firstOk && |highHit) begin
            next_s.phase     = SECOND;
            next_s.candidate = highHit;
            next_s.firstHigh = byteHigh;
            next_s.ackDrive  = 1'b1;
          end else begin
            next_s.phase = IGNORE;
          end
        end
        SECOND: begin
          if (|fullHit) begin
            next_s.phase    = DATA;
            next_s.selected = 1'b1;
            next_s.ackDrive = 1'b1;
            for (int i = NUM_ADDRS - 1; i >= 0; i--) begin
              if (fullHit[i]) begin
                next_s.matchIndex = 2'(i);
              end
            end
          end else begin
            next_s.phase = IGNORE;
          end
        end
        DATA: begin
          next_s.dataValid = 1'b1;
          next_s.dataOut   = byteData;
          next_s.ackDrive  = 1'b1;
        end
        IGNORE: begin
          next_s.phase = IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{phase: IDLE, candidate: '0, firstHigh: 2'h0, ackDrive: 1'b0, selected: 1'b0,
             matchIndex: 2'h0, dataValid: 1'b0, dataOut: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  assign ackDrive   = s.ackDrive;
  assign selected   = s.selected;
  assign matchIndex = s.matchIndex;
  assign dataValid  = s.dataValid;
  assign dataOut    = s.dataOut;

  // a byte taken in the IDLE, SECOND and DATA phases
  sequence firstTaken;
    s.phase == IDLE && byteValid && !startSeen && !stopSeen && multiEnable;
  endsequence

  sequence secondTaken;
    s.phase == SECOND && byteValid && !startSeen && !stopSeen && multiEnable;
  endsequence

  sequence dataTaken;
    s.phase == DATA && byteValid && !startSeen && !stopSeen && multiEnable;
  endsequence

  // frame boundary or matching switched off
  sequence frameCut;
    startSeen || stopSeen || !multiEnable;
  endsequence

  // second ack means one address matched all ten bits
  AST_FULL_MATCH: assert property (@(posedge clk) disable iff (rst)
    secondTaken |=> (ackDrive == $past(anyFull)))
    else $error("second byte ack disagrees with full match");

  // first byte answer
  AST_FIRST_ACK: assert property (@(posedge clk) disable iff (rst)
    firstTaken |=> (ackDrive == $past(firstPass)))
    else $error("first byte ack disagrees with upper-bit match");

  AST_DATA_ONLY_SELECTED: assert property (@(posedge clk) disable iff (rst)
    dataValid |-> selected && $past(s.phase) == DATA)
    else $error("data passed without full match");

  AST_NACK_IGNORE: assert property (@(posedge clk) disable iff (rst)
    s.phase == IGNORE |-> !ackDrive && !dataValid)
    else $error("ack or data while ignoring");

  AST_INDEX_REAL: assert property (@(posedge clk) disable iff (rst)
    $rose(selected) |-> lowOf(matchedAddr) == $past(byteData))
    else $error("selected index does not own the low byte");

  // ten bits of the selected identity came from one address
  AST_SAME_IDENTITY: assert property (@(posedge clk) disable iff (rst)
    $rose(selected) |-> matchedOn && highOf(matchedAddr) == s.firstHigh)
    else $error("selected identity mixes bits of two addresses");

  AST_DATA_PASS: assert property (@(posedge clk) disable iff (rst)
    dataTaken |=> dataValid && ackDrive && dataOut == $past(byteData))
    else $error("data byte of a selected frame not passed on");

  AST_FRAME_CUT: assert property (@(posedge clk) disable iff (rst)
    frameCut |=> !selected && !ackDrive && !dataValid)
    else $error("frame boundary did not return to idle");

  AST_IGNORE_HOLDS: assert property (@(posedge clk) disable iff (rst)
    s.phase == IGNORE && !startSeen && !stopSeen && multiEnable |=> s.phase == IGNORE)
    else $error("ignored frame left the ignore phase");

  // ack only answers a byte just taken
  AST_ACK_CAUSE: assert property (@(posedge clk) disable iff (rst)
    ackDrive |-> $past(byteValid) && $past(s.phase) != IGNORE)
    else $error("ack without a byte to answer");

  // index holds while selected
  AST_INDEX_HOLD: assert property (@(posedge clk) disable iff (rst)
    selected && $past(selected) |-> $stable(matchIndex))
    else $error("matched index changed while selected");

endmodule // i2c_tenbit_match

// ---- tb/i2c_ctl_model.sv ----
// controller model handing framed bytes to the matcher
module i2c_ctl_model (
  // clock
  input  wire logic       clk,
  // byte stream
  output logic            startSeen,
  output logic            stopSeen,
  output logic            byteValid,
  output logic [7:0]      byteData
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {startSeen, stopSeen, byteValid, byteData} = 11'h000;
  task automatic mark(input logic stop);
    @(posedge clk) {stopSeen, startSeen} <= {stop, ~stop};
    @(posedge clk) {stopSeen, startSeen} <= 2'h0;
    #1;
  endtask
  task automatic frame(input logic [7:0] b);
    @(posedge clk) {byteValid, byteData} <= {1'b1, b};
    @(posedge clk) {byteValid, byteData} <= {1'b0, ~b};
    #1;
  endtask
endmodule // i2c_ctl_model

// ---- tb/i2c_multi_address_ten_bit_match_tb_top.sv ----
// bench for the ten-bit multi-address matcher
module i2c_multi_address_ten_bit_match_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
  logic        clk = 1'b0, rst = 1'b1, multiEnable = 1'b1;
  logic        startSeen, stopSeen, byteValid, ackDrive, selected, dataValid;
  logic [3:0]  ownEnable = 4'hf;
  logic [39:0] ownAddr = 40'h0;
  logic [7:0]  byteData, dataOut, lastData = 8'h00;
  logic [1:0]  matchIndex;
  int          num_errors = 0, compares = 0, seed = 66238;
  always #12.5 clk = ~clk;
  i2c_tenbit_match dut_u (.clk(clk), .rst(rst), .multiEnable(multiEnable), .ownEnable(ownEnable),
    .ownAddr(ownAddr), .startSeen(startSeen), .stopSeen(stopSeen), .byteValid(byteValid),
    .byteData(byteData), .ackDrive(ackDrive), .selected(selected), .matchIndex(matchIndex),
    .dataValid(dataValid), .dataOut(dataOut));
  i2c_ctl_model ctl_u (.clk(clk), .startSeen(startSeen), .stopSeen(stopSeen), .byteValid(byteValid),
    .byteData(byteData));
  function automatic logic hiHit(input logic [1:0] h);
    hiHit = 1'b0;
    for (int i = 0; i < 4; i++) hiHit |= multiEnable & ownEnable[i] & (ownAddr[i*10+8+:2] === h);
  endfunction
  function automatic logic [2:0] fullHit(input logic [9:0] a);
    fullHit = 3'h0;
    for (int i = 3; i >= 0; i--) if (multiEnable && ownEnable[i] && ownAddr[i*10+:10] === a) fullHit = {1'b1, 2'(i)};
  endfunction
  task automatic addr(input logic [9:0] a, input logic [7:0] d);
    logic [2:0] f;
    ctl_u.mark(1'b0);
    f = fullHit(a);
    ctl_u.frame({5'h1e, a[9:8], 1'b0});
    `CHK(ackDrive, hiHit(a[9:8]))
    ctl_u.frame(a[7:0]);
    `CHK({ackDrive, selected}, {2{f[2]}})
    if (f[2]) `CHK(matchIndex, f[1:0])
    ctl_u.frame(d);
    `CHK({dataValid, ackDrive, dataOut}, {f[2], f[2], f[2] ? d : lastData})
    if (f[2]) lastData = d;
    ctl_u.mark(1'b1);
    `CHK(selected, 1'b0)
  endtask
  task automatic summarize;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25ns * 20000);
    num_errors++;
    summarize();
  end
  initial begin
    logic [39:0] r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 60; n++) begin
      r = 40'({$random(seed), $random(seed)});
      if (n < 8) for (int i = 1; i < 4; i++) r[i*10+8+:2] = r[9:8];
      @(posedge clk) {ownAddr, ownEnable} <= {r, n < 20 ? 4'hf : 4'($random(seed))};
      addr(r[($unsigned($random(seed)) % 4)*10+:10], 8'($random(seed)));
      addr({r[9:8], r[17:10]}, 8'($random(seed)));
      addr(10'($random(seed)), 8'($random(seed)));
      ctl_u.mark(1'b0);
      ctl_u.frame({5'h0e, ownAddr[9:8], 1'b0});
      `CHK(ackDrive, 1'b0)
      $display("test %0d done", n);
    end
    // corner: matching switched off
    @(posedge clk) {multiEnable, ownEnable} <= {1'b0, 4'hf};
    addr(ownAddr[9:0], 8'h5a);
    @(posedge clk) multiEnable <= 1'b1;
    // corner: read direction, then reset in mid-frame
    ctl_u.mark(1'b0);
    ctl_u.frame({5'h1e, ownAddr[9:8], 1'b1});
    ctl_u.frame(ownAddr[7:0]);
    `CHK({ackDrive, selected, matchIndex}, 4'hc)
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    `CHK({ackDrive, selected, matchIndex, dataValid, dataOut}, 13'h0000)
    lastData = 8'h00;
    $display("corner tests done");
    summarize();
  end
endmodule // i2c_multi_address_ten_bit_match_tb_top
